// >>> hw/rtc_pkg.sv
`default_nettype none
package rtc_pkg;

  // ****************************************************
  // register map
  // ****************************************************
  localparam int          NUM_CH               = 4;
  localparam logic [7:0]  ADDR_EVENT_FLAGS     = 8'h01;
  localparam logic [7:0]  ADDR_RECOVERY_STATUS = 8'h02;
  localparam logic [7:0]  ADDR_EQ_BOOST_OVR    = 8'h03;
  localparam logic [7:0]  ADDR_EQ_CONTROL      = 8'h2d;
  localparam logic [7:0]  ADDR_CHAN_SELECT     = 8'hff;

  localparam logic [7:0]  RST_EVENT_FLAGS      = 8'h00;
  localparam logic [7:0]  RST_RECOVERY_STATUS  = 8'h00;
  localparam logic [7:0]  RST_EQ_BOOST_OVR     = 8'h00;
  localparam logic [7:0]  RST_EQ_CONTROL       = 8'h00;
  localparam logic [7:0]  RST_CHAN_SELECT      = 8'h00;
  localparam logic [7:0]  RDATA_NONE           = 8'h00;

  // ****************************************************
  // field positions
  // ****************************************************
  localparam int          FLAG_SIGNAL_LOSS     = 0;
  localparam int          FLAG_LOCK_LOSS       = 4;
  localparam int          ST_PPM_MET           = 7;
  localparam int          ST_ADAPT_DONE        = 6;
  localparam int          ST_LOCK_FAIL         = 5;
  localparam int          ST_LOCK_A            = 4;
  localparam int          ST_LOCK_B            = 3;
  localparam int          ST_TRANS_MET         = 2;
  localparam int          ST_LPF_OVER          = 1;
  localparam int          EQ_FORCE_BIT         = 3;

  // ****************************************************
  // channel select encoding
  // ****************************************************
  localparam logic [3:0]  SEL_UPPER_ZERO       = 4'h0;
  localparam logic [1:0]  SEL_TAG_UNICAST      = 2'h1;
  localparam logic [1:0]  SEL_TAG_BROADCAST    = 2'h3;

  // ****************************************************
  // carriers
  // ****************************************************
  typedef struct packed {
    logic sig_detect;
    logic ppm_ok;
    logic adapt_done;
    logic lock_fail;
    logic cdr_lock;
    logic transitions_met;
    logic loop_filter_over_limit;
  } rtc_status_t;

  typedef struct packed {
    logic [7:0] event_flags;
    logic [7:0] recovery_status;
    logic [7:0] eq_boost_override;
    logic [7:0] eq_control;
  } rtc_chan_regs_t;

endpackage
`default_nettype wire

// >>> hw/rtc_channel.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_channel (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_reset_n,
  input  wire logic                  i_en,
  input  wire logic                  i_wr,
  input  wire logic                  i_flag_rd,
  input  wire logic [7:0]            i_addr,
  input  wire logic [7:0]            i_wdata,
  input  wire rtc_pkg::rtc_status_t  i_status,
  output var  rtc_pkg::rtc_chan_regs_t o_regs,
  output logic                       o_eq_force,
  output logic [7:0]                 o_eq_boost
);

  // ****************************************************
  // next-state logic
  // ****************************************************
  logic       sig_seen_q;
  logic       sig_prev_q;
  logic       lock_prev_q;
  wire        sig_loss_evt;
  wire        lock_loss_evt;
  wire [7:0]  flags_d;
  wire [7:0]  status_d;
  wire [7:0]  boost_d;
  wire [7:0]  eqctl_d;

  assign sig_loss_evt  = sig_seen_q & sig_prev_q & ~i_status.sig_detect;
  assign lock_loss_evt = lock_prev_q & ~i_status.cdr_lock;

  assign flags_d = {3'h0,
    lock_loss_evt | (o_regs.event_flags[rtc_pkg::FLAG_LOCK_LOSS] & ~i_flag_rd),
    3'h0,
    sig_loss_evt | (o_regs.event_flags[rtc_pkg::FLAG_SIGNAL_LOSS] & ~i_flag_rd)};

  assign status_d = {i_status.ppm_ok, i_status.adapt_done,
                     i_status.lock_fail, i_status.cdr_lock,
                     i_status.cdr_lock, i_status.transitions_met,
                     i_status.loop_filter_over_limit, 1'b0};

  assign boost_d = (i_wr && i_addr == rtc_pkg::ADDR_EQ_BOOST_OVR) ?
                   i_wdata : o_regs.eq_boost_override;
  assign eqctl_d = (i_wr && i_addr == rtc_pkg::ADDR_EQ_CONTROL) ?
                   i_wdata : o_regs.eq_control;

  // ****************************************************
  // state
  // ****************************************************
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sig_seen_q                <= 1'b0;
      sig_prev_q                <= 1'b0;
      lock_prev_q               <= 1'b0;
      o_regs.event_flags        <= rtc_pkg::RST_EVENT_FLAGS;
      o_regs.recovery_status    <= rtc_pkg::RST_RECOVERY_STATUS;
      o_regs.eq_boost_override  <= rtc_pkg::RST_EQ_BOOST_OVR;
      o_regs.eq_control         <= rtc_pkg::RST_EQ_CONTROL;
      o_eq_force                <= 1'b0;
      o_eq_boost                <= 8'h00;
    end else if (i_en) begin
      sig_seen_q                <= sig_seen_q | i_status.sig_detect;
      sig_prev_q                <= i_status.sig_detect;
      lock_prev_q               <= i_status.cdr_lock;
      o_regs.event_flags        <= flags_d;
      o_regs.recovery_status    <= status_d;
      o_regs.eq_boost_override  <= boost_d;
      o_regs.eq_control         <= eqctl_d;
      o_eq_force                <= eqctl_d[rtc_pkg::EQ_FORCE_BIT];
      o_eq_boost                <= eqctl_d[rtc_pkg::EQ_FORCE_BIT] ?
                                   boost_d : 8'h00;
    end
  end

  // ****************************************************
  // checks
  // ****************************************************
  sequence s_sig_acquired_lost;
    i_en && sig_seen_q && sig_prev_q && !i_status.sig_detect;
  endsequence

  sequence s_lock_dropped;
    i_en && lock_prev_q && !i_status.cdr_lock;
  endsequence

  a_sig_loss_set: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    s_sig_acquired_lost |=> o_regs.event_flags[rtc_pkg::FLAG_SIGNAL_LOSS])
    else $error("signal loss flag not set");

  a_sig_loss_hold: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    i_en && !i_flag_rd && o_regs.event_flags[rtc_pkg::FLAG_SIGNAL_LOSS]
    |=> o_regs.event_flags[rtc_pkg::FLAG_SIGNAL_LOSS])
    else $error("signal loss flag dropped without read");

  a_lock_loss_set: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    s_lock_dropped |=> o_regs.event_flags[rtc_pkg::FLAG_LOCK_LOSS])
    else $error("lock loss flag not set");

  a_flag_read_clear: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    i_en && i_flag_rd && !lock_loss_evt
    |=> !o_regs.event_flags[rtc_pkg::FLAG_LOCK_LOSS])
    else $error("lock loss flag not cleared by read");

  a_ppm_bit: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    i_en |=> o_regs.recovery_status[rtc_pkg::ST_PPM_MET]
             == $past(i_status.ppm_ok))
    else $error("ppm bit mismatch");

  a_adapt_fail_bits: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    i_en |=> o_regs.recovery_status[rtc_pkg::ST_ADAPT_DONE]
             == $past(i_status.adapt_done) &&
             o_regs.recovery_status[rtc_pkg::ST_LOCK_FAIL]
             == $past(i_status.lock_fail))
    else $error("adapt or lock-fail bit mismatch");

  a_lock_bits_twin: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    o_regs.recovery_status[rtc_pkg::ST_LOCK_A]
    == o_regs.recovery_status[rtc_pkg::ST_LOCK_B])
    else $error("lock bits differ");

  a_trans_lpf_bits: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    i_en |=> o_regs.recovery_status[rtc_pkg::ST_TRANS_MET]
             == $past(i_status.transitions_met) &&
             o_regs.recovery_status[rtc_pkg::ST_LPF_OVER]
             == $past(i_status.loop_filter_over_limit))
    else $error("transition or loop filter bit mismatch");

  a_status_ro: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    i_en && i_wr && i_addr == rtc_pkg::ADDR_RECOVERY_STATUS
    |=> o_regs.recovery_status[0] == 1'b0 &&
        o_regs.recovery_status[rtc_pkg::ST_LOCK_A]
        == $past(i_status.cdr_lock))
    else $error("status byte changed by write");

  a_force_gate: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    o_eq_boost != 8'h00 |-> o_eq_force &&
      o_regs.eq_control[rtc_pkg::EQ_FORCE_BIT] &&
      o_eq_boost == o_regs.eq_boost_override)
    else $error("boost forced without enable");

endmodule // rtc_channel
`default_nettype wire

// >>> hw/rtc_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - signal-loss flag set only after acquire-then-loss
// - status bit 7 reports rate within tolerance
// - status bit 6 reports equalizer adaptation done
// - status bit 5 reports signal unfit for lock
// - status bits 4 and 3 both show lock
// - status bit 2 reports enough transitions seen
// - status bit 1 reports rate above oscillator
// - status byte read only, resets zero
// - boost forced only with control bit 3
// - lock-loss flag sets on drop, read clears
// - channel select routes later channel accesses
module rtc_status_regs #(
  parameter int NUM_CH = rtc_pkg::NUM_CH
) (
  input  wire logic                              i_ref_clk,
  input  wire logic                              i_reset_n,
  input  wire logic                              i_clk_en,
  input  wire logic                              i_reg_wr,
  input  wire logic                              i_reg_rd,
  input  wire logic [7:0]                        i_reg_addr,
  input  wire logic [7:0]                        i_reg_wdata,
  input  wire rtc_pkg::rtc_status_t [NUM_CH-1:0] i_chan_status,
  output logic [7:0]                             o_reg_rdata,
  output logic                                   o_reg_rvalid,
  output logic [NUM_CH-1:0]                      o_eq_force,
  output logic [NUM_CH-1:0][7:0]                 o_eq_boost
);

  // ****************************************************
  // helpers
  // ****************************************************
  function automatic logic [7:0] reg_pick(
    input rtc_pkg::rtc_chan_regs_t regs,
    input logic [7:0]              addr
  );
    logic [7:0] val;
    val = rtc_pkg::RDATA_NONE;
    case (addr)
      rtc_pkg::ADDR_EVENT_FLAGS:     val = regs.event_flags;
      rtc_pkg::ADDR_RECOVERY_STATUS: val = regs.recovery_status;
      rtc_pkg::ADDR_EQ_BOOST_OVR:    val = regs.eq_boost_override;
      rtc_pkg::ADDR_EQ_CONTROL:      val = regs.eq_control;
      default:                       val = rtc_pkg::RDATA_NONE;
    endcase
    return val;
  endfunction

  function automatic logic sel_is(
    input logic [7:0] sel,
    input logic [1:0] tag
  );
    return sel[7:4] == rtc_pkg::SEL_UPPER_ZERO && sel[3:2] == tag;
  endfunction

  // ****************************************************
  // channel select
  // ****************************************************
  logic [7:0] sel_q;
  wire        sel_wr;
  wire        sel_unicast;
  wire        sel_bcast;
  wire        sel_chan;
  wire [1:0]  sel_idx;
  wire        acc_chan;

  assign sel_wr      = i_reg_wr && i_reg_addr == rtc_pkg::ADDR_CHAN_SELECT;
  assign sel_unicast = sel_is(sel_q, rtc_pkg::SEL_TAG_UNICAST);
  assign sel_bcast   = sel_is(sel_q, rtc_pkg::SEL_TAG_BROADCAST);
  assign sel_chan    = sel_unicast | sel_bcast;
  assign sel_idx     = sel_q[1:0];
  assign acc_chan    = sel_chan && i_reg_addr != rtc_pkg::ADDR_CHAN_SELECT;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel_q <= rtc_pkg::RST_CHAN_SELECT;
    end else if (i_clk_en && sel_wr) begin
      sel_q <= i_reg_wdata;
    end
  end

  // ****************************************************
  // channel slices
  // ****************************************************
  rtc_pkg::rtc_chan_regs_t [NUM_CH-1:0] chan_regs;
  wire [NUM_CH-1:0]                     chan_wr;
  wire [NUM_CH-1:0]                     chan_flag_rd;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_chan
      assign chan_wr[g] = i_reg_wr && acc_chan &&
                          (sel_bcast || sel_idx == 2'(g));
      assign chan_flag_rd[g] = i_reg_rd && acc_chan &&
                               sel_idx == 2'(g) &&
                               i_reg_addr == rtc_pkg::ADDR_EVENT_FLAGS;

      rtc_channel u_chan (
        .i_ref_clk  (i_ref_clk),
        .i_reset_n  (i_reset_n),
        .i_en       (i_clk_en),
        .i_wr       (chan_wr[g]),
        .i_flag_rd  (chan_flag_rd[g]),
        .i_addr     (i_reg_addr),
        .i_wdata    (i_reg_wdata),
        .i_status   (i_chan_status[g]),
        .o_regs     (chan_regs[g]),
        .o_eq_force (o_eq_force[g]),
        .o_eq_boost (o_eq_boost[g])
      );
    end
  endgenerate

  // ****************************************************
  // read path
  // ****************************************************
  wire [7:0] rdata_d;

  assign rdata_d = acc_chan ? reg_pick(chan_regs[sel_idx], i_reg_addr)
                            : rtc_pkg::RDATA_NONE;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata  <= rtc_pkg::RDATA_NONE;
      o_reg_rvalid <= 1'b0;
    end else if (i_clk_en) begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= rdata_d;
      end
    end
  end

  // ****************************************************
  // checks
  // ****************************************************
  a_read_answer: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    i_clk_en && i_reg_rd |=> o_reg_rvalid &&
      o_reg_rdata == $past(rdata_d))
    else $error("read answer missing or wrong");

  a_select_write: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    i_clk_en && sel_wr |=> sel_q == $past(i_reg_wdata))
    else $error("channel select not captured");

  a_route_unicast: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    sel_unicast && i_reg_wr && acc_chan
    |-> chan_wr == NUM_CH'(1) << sel_idx)
    else $error("unicast write reaches wrong channel");

  a_route_bcast: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    sel_bcast && i_reg_wr && acc_chan |-> &chan_wr)
    else $error("broadcast write misses a channel");

  a_lpf_bit: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    i_clk_en |=> chan_regs[0].recovery_status[rtc_pkg::ST_LPF_OVER]
      == $past(i_chan_status[0].loop_filter_over_limit))
    else $error("loop filter bit mismatch");

  a_fail_bit: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    i_clk_en |=> chan_regs[0].recovery_status[rtc_pkg::ST_LOCK_FAIL]
      == $past(i_chan_status[0].lock_fail))
    else $error("lock fail bit mismatch");

  a_unmapped_read: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    i_clk_en && i_reg_rd && !acc_chan
    |=> o_reg_rdata == rtc_pkg::RDATA_NONE)
    else $error("read outside a channel not zero");

  a_stray_write: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    !(i_reg_wr && acc_chan) |-> chan_wr == '0)
    else $error("write reaches channel without select");

  a_flag_rd_one: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    $onehot0(chan_flag_rd))
    else $error("flag read clears several channels");

  a_flag_rd_route: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    i_reg_rd && acc_chan && i_reg_addr == rtc_pkg::ADDR_EVENT_FLAGS
    |-> chan_flag_rd == NUM_CH'(1) << sel_idx)
    else $error("flag read clears wrong channel");

  a_rvalid_pulse: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    i_clk_en && !i_reg_rd |=> !o_reg_rvalid)
    else $error("read strobe without read");

  a_freeze_select: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    !i_clk_en |=> $stable(sel_q))
    else $error("select changed while frozen");

  a_freeze_read: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    !i_clk_en |=> $stable(o_reg_rdata) && $stable(o_reg_rvalid))
    else $error("read port changed while frozen");

  a_freeze_boost: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    !i_clk_en |=> $stable(o_eq_force) && $stable(o_eq_boost))
    else $error("boost outputs changed while frozen");

  a_freeze_status: assert property (
    @(posedge i_ref_clk) disable iff (!i_reset_n)
    !i_clk_en |=> $stable(chan_regs[0].recovery_status))
    else $error("status byte changed while frozen");

endmodule // rtc_status_regs
`default_nettype wire

// >>> tb/rtc_status_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_status_regs_bench;

  localparam int NCH = rtc_pkg::NUM_CH;

  logic                             clk;
  logic                             rst_n;
  logic                             clk_en;
  logic                             reg_wr;
  logic                             reg_rd;
  logic [7:0]                       addr;
  logic [7:0]                       wdata;
  logic [7:0]                       rdata;
  logic                             rvalid;
  rtc_pkg::rtc_status_t [NCH-1:0]   st;
  logic [NCH-1:0]                   eq_force;
  logic [NCH-1:0][7:0]              eq_boost;
  int                               n_errors;
  int                               compares;
  logic [31:0]                      seed;
  logic [7:0]                       v;

  rtc_status_regs #(
    .NUM_CH (NCH)
  ) i_rtc_status_regs (
    .i_ref_clk     (clk),
    .i_reset_n     (rst_n),
    .i_clk_en      (clk_en),
    .i_reg_wr      (reg_wr),
    .i_reg_rd      (reg_rd),
    .i_reg_addr    (addr),
    .i_reg_wdata   (wdata),
    .i_chan_status (st),
    .o_reg_rdata   (rdata),
    .o_reg_rvalid  (rvalid),
    .o_eq_force    (eq_force),
    .o_eq_boost    (eq_boost)
  );

  // ****************************************************
  // helpers
  // ****************************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [7:0] exp_st(input rtc_pkg::rtc_status_t s);
    return {s.ppm_ok, s.adapt_done, s.lock_fail, s.cdr_lock, s.cdr_lock,
            s.transitions_met, s.loop_filter_over_limit, 1'b0};
  endfunction

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    addr   = a;
    wdata  = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic rdc(input string what, input logic [7:0] a,
                     input logic [7:0] exp);
    @(negedge clk);
    reg_rd = 1'b1;
    addr   = a;
    @(negedge clk);
    reg_rd = 1'b0;
    check("read strobe", {7'h00, rvalid}, 8'h01);
    check(what, rdata, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ****************************************************
  // clock and watchdog
  // ****************************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    // about fifteen times the expected test length
    #(20 * 5000);
    n_errors++;
    $display("[FAIL] watchdog expected finish seen hang");
    final_report();
  end

  // ****************************************************
  // tests
  // ****************************************************
  initial begin
    seed = 32'd97398;
    n_errors = 0;
    compares = 0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    st = '0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;

    rdc("shared set read", 8'h03, 8'h00);
    wr(8'hff, 8'h04);
    rdc("flags reset", 8'h01, 8'h00);
    rdc("status reset", 8'h02, 8'h00);
    rdc("boost reset", 8'h03, 8'h00);
    rdc("eq ctrl reset", 8'h2d, 8'h00);
    check("force reset", {4'h0, eq_force}, 8'h00);
    $display("test reset done");

    for (int i = 0; i < 8; i++) begin
      for (int k = 0; k < NCH; k++) begin
        st[k] = (i == 0) ? 7'h7f : (i == 1) ? 7'h00 : 7'(xs());
      end
      idle(3);
      for (int k = 0; k < NCH; k++) begin
        wr(8'hff, 8'((i % 2) ? 8'h0c + k : 8'h04 + k));
        wr(8'h02, 8'(xs()));
        rdc("status byte", 8'h02, exp_st(st[k]));
      end
    end
    st = '0;
    idle(3);
    $display("test status done");

    for (int k = 0; k < NCH; k++) begin
      wr(8'hff, 8'(8'h04 + k));
      v = 8'(xs());
      wr(8'h03, v);
      rdc("boost readback", 8'h03, v);
      check("boost unforced", eq_boost[k], 8'h00);
      wr(8'h2d, 8'h08);
      check("force set", {7'h00, eq_force[k]}, 8'h01);
      check("boost forced", eq_boost[k], v);
      wr(8'h2d, 8'h00);
      check("boost released", eq_boost[k], 8'h00);
    end
    wr(8'hff, 8'h0e);
    wr(8'h03, 8'h5a);
    wr(8'h2d, 8'h08);
    for (int k = 0; k < NCH; k++) begin
      check("broadcast boost", eq_boost[k], 8'h5a);
    end
    wr(8'h2d, 8'h00);
    wr(8'hff, 8'h04);
    clk_en = 1'b0;
    wr(8'h03, 8'ha5);
    clk_en = 1'b1;
    rdc("frozen write", 8'h03, 8'h5a);
    $display("test boost done");

    wr(8'hff, 8'h06);
    // both flags latched when the status sweep dropped all inputs
    rdc("flags sticky", 8'h01, 8'h11);
    rdc("flags clear", 8'h01, 8'h00);
    st[2].sig_detect = 1'b1;
    idle(3);
    st[2].sig_detect = 1'b0;
    idle(3);
    rdc("signal loss", 8'h01, 8'h01);
    rdc("signal loss rc", 8'h01, 8'h00);
    st[2].cdr_lock = 1'b1;
    idle(3);
    st[2].cdr_lock = 1'b0;
    idle(3);
    wr(8'hff, 8'h04);
    rdc("other channel", 8'h01, 8'h11);
    rdc("other channel rc", 8'h01, 8'h00);
    wr(8'hff, 8'h0e);
    rdc("lock loss", 8'h01, 8'h10);
    rdc("lock loss rc", 8'h01, 8'h00);
    $display("test flags done");

    rdc("unmapped", 8'h10, 8'h00);
    rdc("select read", 8'hff, 8'h00);
    wr(8'h01, 8'hff);
    rdc("flags ro", 8'h01, 8'h00);
    $display("test access done");
    final_report();
  end

endmodule // rtc_status_regs_bench
`default_nettype wire
